/* logic/amc_map.svh */
/*
 * Constants of the mode-control sequencer: register layout, reset value and timing figures.
 * Assumes inclusion from the package, the link port and the top module only.
 */
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH
`define AMC_REGSEL_MODE 3'h1
`define AMC_MODE_RST 16'h000a
`define AMC_MD_HI 15
`define AMC_MD_LO 13
`define AMC_PSW_BIT 12
`define AMC_RSV_HI 11
`define AMC_RSV_LO 4
`define AMC_FS_HI 3
`define AMC_FS_LO 0
`define AMC_OPM_CONT 3'h0
`define AMC_OPM_SINGLE 3'h1
`define AMC_OPM_IDLE 3'h2
`define AMC_OPM_PDOWN 3'h3
`define AMC_OPM_CAL_BIT 2
`define AMC_MCLK_HZ 64'd20000000
`define AMC_OSC_SETTLE_US 64'd1000
`define AMC_RATE_MHZ {20'd4170, 20'd6250, 20'd8330, 20'd10000, 20'd12500, 20'd16700, \
	20'd16700, 20'd19600, 20'd33300, 20'd39200, 20'd50000, 20'd62500, 20'd125000, \
	20'd250000, 20'd500000, 20'd500000}
`define AMC_RESULT_PERIODS 2'd2
`define AMC_RDY_GUARD_CYC 23'h000040
`endif

/* logic/amc_pkg.sv */
/*
 * Types and table builders of the mode-control sequencer.
 * Assumes the constants header is on the include path.
 */
package amc_pkg;
`include "amc_map.svh"
	typedef logic [2:0] amc_opmode_t;
	typedef logic [15:0] amc_word_t;
	typedef logic [22:0] amc_cnt_t;
	typedef logic [15:0][22:0] amc_rate_t;
	typedef enum logic [2:0] {AMC_ST_HOLD, AMC_ST_OFF, AMC_ST_SETTLE, AMC_ST_CONV} amc_state_e;

	// Output-rate period in clock cycles per rate code; rates are held in millihertz.
	function automatic amc_rate_t amc_rate_table();
		logic [15:0][19:0] mhz;
		amc_rate_t t;
		mhz = `AMC_RATE_MHZ;
		t = '0;
		for (int i = 0; i < 16; i++)
		begin
			t[i] = 23'((`AMC_MCLK_HZ * 64'd1000) / 64'(mhz[i]));
		end
		return t;
	endfunction : amc_rate_table

	// Oscillator settling is a least time, so it rounds up.
	function automatic amc_cnt_t amc_settle_cycles();
		return 23'((`AMC_OSC_SETTLE_US * `AMC_MCLK_HZ + 64'd999999) / 64'd1000000);
	endfunction : amc_settle_cycles
endpackage : amc_pkg

/* logic/amc_xfer_if.sv */
/*
 * Crossing bundle between the link-clock port and the core of the sequencer.
 * Assumes each word is held stable from its toggle edge until the next toggle.
 */
`timescale 1ns/100ps
interface amc_xfer_if;
	logic wr_tog;
	logic [15:0] wr_word;
	logic rd_tog;
	logic pub_tog;
	logic [15:0] pub_word;
	modport link (output wr_tog, output wr_word, output rd_tog, input pub_tog, input pub_word);
	modport core (input wr_tog, input wr_word, input rd_tog, output pub_tog, output pub_word);
endinterface : amc_xfer_if

/* logic/amc_link_port.sv */
/*
 * Link-clock side of the mode register: shifts words in and out and reports data reads.
 * Assumes the framer drives its strobes on the link clock and keeps frames far apart.
 */
`timescale 1ns/100ps
`include "amc_map.svh"
module amc_link_port
	import amc_pkg::*;
(
	input wire logic link_clk, // link shift clock
	input wire logic rst, // core reset, synchronised here
	amc_xfer_if.link xif, // crossing bundle
	input wire logic frame, // register transfer in progress
	input wire logic [2:0] reg_select, // register addressed by the framer
	input wire logic wr_dir, // high for a write transfer
	input wire logic bit_en, // one bit moves on this edge
	input wire logic sdi, // serial data in
	output logic sdo, // serial data out
	input wire logic data_read // data register read completed
);
	typedef struct packed {
		logic [1:0] rs;
		logic [2:0] psync;
		amc_word_t mirror;
		amc_word_t shreg;
		logic [3:0] bitcnt;
		amc_word_t wr_word;
		logic wr_tog;
		logic rd_tog;
		logic sdo;
	} amc_link_s;

	amc_link_s s_reg;
	amc_link_s s_next;
	logic sel;

	always_comb
	begin
		s_next = s_reg;
		s_next.rs = {s_reg.rs[0], rst};
		s_next.psync = {s_reg.psync[1:0], xif.pub_tog};
		sel = frame && (reg_select == `AMC_REGSEL_MODE);
		if (s_reg.psync[2] != s_reg.psync[1])
		begin
			s_next.mirror = xif.pub_word;
		end
		if (data_read)
		begin
			s_next.rd_tog = ~s_reg.rd_tog;
		end
		if (!sel)
		begin
			s_next.bitcnt = 4'h0;
			s_next.shreg = s_reg.mirror;
			s_next.sdo = s_reg.mirror[15];
		end
		else if (bit_en)
		begin
			s_next.shreg = {s_reg.shreg[14:0], sdi};
			s_next.sdo = s_reg.shreg[14];
			s_next.bitcnt = s_reg.bitcnt + 4'h1;
			if (wr_dir && s_reg.bitcnt == 4'hf)
			begin
				s_next.wr_word = {s_reg.shreg[14:0], sdi};
				s_next.wr_tog = ~s_reg.wr_tog;
			end
		end
		if (s_reg.rs[1])
		begin
			s_next = '0;
			s_next.rs = {s_reg.rs[0], rst};
			s_next.mirror = `AMC_MODE_RST;
			s_next.shreg = `AMC_MODE_RST;
		end
	end

	always_ff @(posedge link_clk)
	begin
		s_reg <= s_next;
	end

	assign xif.wr_tog = s_reg.wr_tog;
	assign xif.wr_word = s_reg.wr_word;
	assign xif.rd_tog = s_reg.rd_tog;
	assign sdo = s_reg.sdo;
endmodule : amc_link_port

/* logic/amc_mode_ctrl.sv */
/*
 * Mode-control sequencer of a sigma-delta converter: mode register, conversion timing,
 * result-ready flag, modulator reset, power-down and low-side switch control.
 * Assumes a serial framer on the link clock and a modulator result on the core clock.
 */
// Summary of operation
// - Mode register at select code 001, resets to 0x000a.
// - Mode register words shift most significant bit first.
// - Any mode write resets modulator and filter and marks result not ready.
// - Mode field sits in bits 15..13, rate field in bits 3..0.
// - Switch bit set closes the low-side switch, cleared opens it.
// - Power-down always opens the low-side switch.
// - Continuous mode converts repeatedly, stores results, drives ready low each time.
// - First continuous result after two rate periods, then one per period.
// - Single mode: settle 1 ms, two periods, store, ready low, power down.
// - Single result and ready low are kept until read or next conversion.
// - Idle holds modulator and filter in reset, modulator clock still running.
// - Power-down disables converter circuitry including burnout currents.
// - Ready clears on new result; sets on read, before update, on power-down.
// - Calibration codes run two cycles, store coefficient, then go idle.
// - Rate codes 0001..1111 span 500 Hz down to 4.17 Hz; 0000 reserved.
`timescale 1ns/100ps
`include "amc_map.svh"
module amc_mode_ctrl
	import amc_pkg::*;
#(
	parameter int DATA_W = 24,
	parameter amc_rate_t RATE_CYC = amc_rate_table(),
	parameter amc_cnt_t SETTLE_CYC = amc_settle_cycles()
)
(
	input wire logic mclk, // core clock, internal oscillator
	input wire logic rst, // synchronous reset, active high
	input wire logic link_clk, // serial link clock
	input wire logic link_frame, // framer: register transfer in progress
	input wire logic [2:0] link_reg_select, // framer: addressed register
	input wire logic link_write, // framer: transfer is a write
	input wire logic link_bit_en, // framer: a bit moves on this edge
	input wire logic link_sdi, // serial data in
	output logic link_sdo, // serial data out
	input wire logic link_data_read, // framer: data register read done
	input wire logic [DATA_W-1:0] conv_result, // modulator and filter output
	output logic [DATA_W-1:0] data_word, // data register
	output logic data_ready_n, // low while an unread result stands
	output logic mod_reset, // modulator and filter held in reset
	output logic mod_clk_en, // modulator clocks running
	output logic conv_power_en, // converter circuitry powered
	output logic burnout_en, // burnout sources allowed
	output logic switch_close, // low-side switch closed to ground
	output logic cal_active, // calibration in progress
	output logic cal_system, // calibration uses the system input
	output logic coef_store_offset, // store zero-scale coefficient
	output logic coef_store_fullscale, // store full-scale coefficient
	output logic [15:0] mode_word // mode register contents
);
	//**************************************************************
	// Crossing to the link clock
	//**************************************************************
	amc_xfer_if xif ();

	amc_link_port u_link
	(
		.link_clk(link_clk),
		.rst(rst),
		.xif(xif),
		.frame(link_frame),
		.reg_select(link_reg_select),
		.wr_dir(link_write),
		.bit_en(link_bit_en),
		.sdi(link_sdi),
		.sdo(link_sdo),
		.data_read(link_data_read)
	);

	//**************************************************************
	// State
	//**************************************************************
	typedef struct packed {
		amc_word_t mode;
		amc_state_e st;
		amc_cnt_t cnt;
		logic [1:0] pcnt;
		logic [DATA_W-1:0] data;
		logic ready_n;
		logic mod_rst;
		logic clk_en;
		logic pwr_en;
		logic sw_close;
		logic cal_act;
		logic cal_sys;
		logic coef_ofs;
		logic coef_fs;
		logic [2:0] wsync;
		logic [2:0] rsync;
		amc_word_t pub_word;
		logic pub_tog;
	} amc_core_s;

	amc_core_s s_reg;
	amc_core_s s_next;
	amc_core_s s_rst;
	amc_opmode_t opm;
	amc_opmode_t new_opm;
	amc_cnt_t period;
	logic wr_evt;
	logic rd_evt;
	logic period_end;

	function automatic logic is_cal(amc_opmode_t m);
		return m[`AMC_OPM_CAL_BIT];
	endfunction : is_cal

	// Entry state of an operating mode, used after reset and after every mode write.
	function automatic amc_state_e entry_state(amc_opmode_t m);
		amc_state_e e;
		e = AMC_ST_CONV;
		if (m == `AMC_OPM_SINGLE)
		begin
			e = AMC_ST_SETTLE;
		end
		else if (m == `AMC_OPM_IDLE)
		begin
			e = AMC_ST_HOLD;
		end
		else if (m == `AMC_OPM_PDOWN)
		begin
			e = AMC_ST_OFF;
		end
		return e;
	endfunction : entry_state

	always_comb
	begin
		s_rst = '0;
		s_rst.mode = `AMC_MODE_RST;
		s_rst.pub_word = `AMC_MODE_RST;
		s_rst.st = entry_state(3'(`AMC_MODE_RST >> `AMC_MD_LO));
		s_rst.ready_n = 1'b1;
		s_rst.mod_rst = 1'b1;
	end

	//**************************************************************
	// Sequencer
	//**************************************************************
	always_comb
	begin
		s_next = s_reg;
		s_next.wsync = {s_reg.wsync[1:0], xif.wr_tog};
		s_next.rsync = {s_reg.rsync[1:0], xif.rd_tog};
		s_next.coef_ofs = 1'b0;
		s_next.coef_fs = 1'b0;
		wr_evt = s_reg.wsync[2] != s_reg.wsync[1];
		rd_evt = s_reg.rsync[2] != s_reg.rsync[1];
		opm = s_reg.mode[`AMC_MD_HI:`AMC_MD_LO];
		new_opm = xif.wr_word[`AMC_MD_HI:`AMC_MD_LO];
		period = RATE_CYC[s_reg.mode[`AMC_FS_HI:`AMC_FS_LO]];
		period_end = s_reg.cnt == period - 23'h000001;

		if (rd_evt)
		begin
			s_next.ready_n = 1'b1;
		end

		case (s_reg.st)
			AMC_ST_HOLD:
			begin
				s_next.cnt = '0;
			end
			AMC_ST_OFF:
			begin
				s_next.cnt = '0;
			end
			AMC_ST_SETTLE:
			begin
				if (s_reg.cnt == SETTLE_CYC - 23'h000001)
				begin
					s_next.cnt = '0;
					s_next.pcnt = 2'h0;
					s_next.st = AMC_ST_CONV;
				end
				else
				begin
					s_next.cnt = s_reg.cnt + 23'h000001;
				end
			end
			AMC_ST_CONV:
			begin
				if (!period_end)
				begin
					s_next.cnt = s_reg.cnt + 23'h000001;
				end
				else
				begin
					s_next.cnt = '0;
				end
				if (opm == `AMC_OPM_CONT && s_reg.pcnt == `AMC_RESULT_PERIODS - 2'h1 &&
					s_reg.cnt == period - 23'h000001 - `AMC_RDY_GUARD_CYC)
				begin
					s_next.ready_n = 1'b1;
				end
				if (period_end && s_reg.pcnt != `AMC_RESULT_PERIODS - 2'h1)
				begin
					s_next.pcnt = s_reg.pcnt + 2'h1;
				end
				else if (period_end)
				begin
					s_next.ready_n = 1'b0;
					if (is_cal(opm))
					begin
						s_next.coef_ofs = ~opm[0];
						s_next.coef_fs = opm[0];
						s_next.mode[`AMC_MD_HI:`AMC_MD_LO] = `AMC_OPM_IDLE;
						s_next.st = AMC_ST_HOLD;
					end
					else
					begin
						s_next.data = conv_result;
					end
					if (opm == `AMC_OPM_SINGLE)
					begin
						s_next.st = AMC_ST_OFF;
					end
				end
			end
			default:
			begin
				s_next.st = AMC_ST_HOLD;
			end
		endcase

		// A mode write outranks the state, counter and ready updates of the same cycle, but not a result or coefficient store.
		if (wr_evt)
		begin
			s_next.mode = xif.wr_word;
			s_next.ready_n = 1'b1;
			s_next.cnt = '0;
			s_next.pcnt = 2'h0;
			s_next.st = entry_state(new_opm);
		end

		s_next.mod_rst = wr_evt || s_next.st == AMC_ST_HOLD || s_next.st == AMC_ST_OFF ||
			s_next.st == AMC_ST_SETTLE;
		s_next.clk_en = s_next.st != AMC_ST_OFF;
		s_next.pwr_en = s_next.st != AMC_ST_OFF;
		s_next.sw_close = s_next.mode[`AMC_PSW_BIT] && s_next.st != AMC_ST_OFF;
		s_next.cal_act = s_next.st == AMC_ST_CONV &&
			is_cal(s_next.mode[`AMC_MD_HI:`AMC_MD_LO]);
		s_next.cal_sys = s_next.cal_act && s_next.mode[`AMC_MD_LO + 1];

		// The word is stable from the toggle edge on, so the link side may take it
		// once its synchroniser has seen the toggle.
		s_next.pub_word = s_reg.mode;
		s_next.pub_tog = s_reg.pub_tog ^ (s_reg.pub_word != s_reg.mode);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_reg <= s_rst;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	//**************************************************************
	// Outputs
	//**************************************************************
	assign xif.pub_tog = s_reg.pub_tog;
	assign xif.pub_word = s_reg.pub_word;
	assign data_word = s_reg.data;
	assign data_ready_n = s_reg.ready_n;
	assign mod_reset = s_reg.mod_rst;
	assign mod_clk_en = s_reg.clk_en;
	assign conv_power_en = s_reg.pwr_en;
	assign burnout_en = s_reg.pwr_en;
	assign switch_close = s_reg.sw_close;
	assign cal_active = s_reg.cal_act;
	assign cal_system = s_reg.cal_sys;
	assign coef_store_offset = s_reg.coef_ofs;
	assign coef_store_fullscale = s_reg.coef_fs;
	assign mode_word = s_reg.mode;
endmodule : amc_mode_ctrl

/* dv/amc_mode_ctrl_properties.sv */
/*
 * Port checker of the mode-control sequencer.
 * Assumes it is bound onto amc_mode_ctrl and sees only its ports.
 */
`timescale 1ns/100ps
module amc_mode_ctrl_chk
	import amc_pkg::*;
#(
	parameter int DATA_W = 24
)
(
	input wire logic mclk, // core clock
	input wire logic rst, // synchronous reset
	input wire logic [DATA_W-1:0] conv_result, // modulator result
	input wire logic [DATA_W-1:0] data_word, // data register
	input wire logic data_ready_n, // ready flag
	input wire logic mod_reset, // modulator reset
	input wire logic mod_clk_en, // modulator clocks
	input wire logic conv_power_en, // converter power
	input wire logic burnout_en, // burnout sources
	input wire logic switch_close, // low-side switch
	input wire logic coef_store_offset, // offset store pulse
	input wire logic coef_store_fullscale, // full-scale store pulse
	input wire logic [15:0] mode_word // mode register
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Power state is registered with the mode word; the word must also equal its value three cycles earlier.
	property p_pdown_off;
		mode_word[15:13] == 3'h3 && mode_word == $past(mode_word, 3)
			|-> !switch_close && !conv_power_en && data_ready_n;
	endproperty
	a_pdown_off: assert property (p_pdown_off) else $error("power-down not honoured");
	property p_switch_on;
		mode_word[15:12] == 4'h1 && mode_word == $past(mode_word, 2) |-> switch_close;
	endproperty
	a_switch_on: assert property (p_switch_on) else $error("switch not closed");
	property p_write_ready;
		$changed(mode_word) && !$past(mode_word[15]) |-> ##[0:1] data_ready_n;
	endproperty
	a_write_ready: assert property (p_write_ready) else $error("ready not set on write");
	property p_write_reset;
		$changed(mode_word) && !$past(mode_word[15]) |-> ##[0:1] mod_reset;
	endproperty
	a_write_reset: assert property (p_write_reset) else $error("no reset on write");
	property p_idle_hold;
		mode_word[15:13] == 3'h2 && $stable(mode_word) |-> mod_reset && mod_clk_en;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle not held in reset");
	property p_burnout;
		burnout_en == conv_power_en;
	endproperty
	a_burnout: assert property (p_burnout) else $error("burnout not tied to power");
	property p_store;
		$fell(data_ready_n) && mode_word[15:14] == 2'b00 && $stable(mode_word)
			|-> data_word == $past(conv_result);
	endproperty
	a_store: assert property (p_store) else $error("result not stored");
	property p_cal_idle;
		$rose(coef_store_offset | coef_store_fullscale) |-> ##[0:2] mode_word[15:13] == 3'h2;
	endproperty
	a_cal_idle: assert property (p_cal_idle) else $error("no idle after calibration");
	property p_coef_pulse;
		coef_store_offset || coef_store_fullscale |=> !coef_store_offset && !coef_store_fullscale;
	endproperty
	a_coef_pulse: assert property (p_coef_pulse) else $error("store pulse too long");
	property p_clk_pdown;
		!mod_clk_en |-> !conv_power_en;
	endproperty
	a_clk_pdown: assert property (p_clk_pdown) else $error("clocks stopped outside power-down");
	c_result: cover property ($fell(data_ready_n));
	c_cal: cover property (coef_store_fullscale);
	c_pdown: cover property (!conv_power_en);
endmodule : amc_mode_ctrl_chk
bind amc_mode_ctrl amc_mode_ctrl_chk #(.DATA_W(DATA_W)) amc_mode_ctrl_chk_i (.mclk(mclk),
	.rst(rst), .conv_result(conv_result), .data_word(data_word), .data_ready_n(data_ready_n),
	.mod_reset(mod_reset), .mod_clk_en(mod_clk_en), .conv_power_en(conv_power_en),
	.burnout_en(burnout_en), .switch_close(switch_close), .coef_store_offset(coef_store_offset),
	.coef_store_fullscale(coef_store_fullscale), .mode_word(mode_word));

/* dv/amc_host_model.sv */
/*
 * Host model on the serial register link: makes the link clock and shifts words.
 * Assumes the bench calls its tasks one at a time.
 */
`timescale 1ns/100ps
module amc_host_model
(
	output logic link_clk, // link clock, also runs outside frames
	output logic link_frame, // transfer in progress
	output logic [2:0] link_reg_select, // addressed register
	output logic link_write, // write transfer
	output logic link_bit_en, // bit moves on this edge
	output logic link_sdi, // data to the device
	output logic link_data_read, // data read finished
	input wire logic link_sdo // data from the device
);
	// ****************************************
	// Link tasks
	// ****************************************
	initial
	begin
		link_clk = 1'b0;
		link_frame = 1'b0;
		link_reg_select = 3'h0;
		link_write = 1'b0;
		link_bit_en = 1'b0;
		link_sdi = 1'b0;
		link_data_read = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n)
		begin
			#6 link_clk = 1'b1;
			#6 link_clk = 1'b0;
		end
	endtask : tick
	// select first, then sixteen bits from the top
	task automatic xfer(input logic [2:0] sel, input logic wr, input logic [15:0] wd,
		output logic [15:0] rd);
		// Lead-in edges with the frame low let the readback mirror reach the shifter.
		tick(4);
		link_frame = 1'b1;
		link_reg_select = sel;
		link_write = wr;
		for (int i = 15; i >= 0; i--)
		begin
			link_sdi = wd[i];
			link_bit_en = 1'b1;
			#5 rd[i] = link_sdo;
			#1 link_clk = 1'b1;
			#6 link_clk = 1'b0;
		end
		link_bit_en = 1'b0;
		link_sdi = ~link_sdi;
		// Trailing edges let the crossing settle before the frame closes.
		tick(8);
		link_frame = 1'b0;
	endtask : xfer
	task automatic rd_pulse();
		link_frame = 1'b1;
		link_reg_select = 3'h3;
		link_write = 1'b0;
		link_data_read = 1'b1;
		tick(1);
		link_data_read = 1'b0;
		tick(4);
		link_frame = 1'b0;
	endtask : rd_pulse
endmodule : amc_host_model

/* dv/amc_mode_ctrl_tb_top.sv */
/*
 * Testbench of the mode-control sequencer with shortened periods.
 * Assumes the checker is bound and the host model drives the link.
 */
`timescale 1ns/100ps
module amc_mode_ctrl_tb_top
	import amc_pkg::*;
;
	logic mclk, rst, link_clk, link_frame, link_write, link_bit_en, link_sdi, link_sdo;
	logic link_data_read, data_ready_n, mod_reset, mod_clk_en, conv_power_en, burnout_en;
	logic switch_close, cal_active, cal_system, coef_store_offset, coef_store_fullscale;
	logic [2:0] link_reg_select;
	logic [23:0] conv_result, data_word;
	logic [15:0] mode_word, d;
	int n_fail, compares, cyc_n, t0, t1, n_off, n_fs;
	amc_host_model amc_host_model_i (.link_clk(link_clk), .link_frame(link_frame),
		.link_reg_select(link_reg_select), .link_write(link_write), .link_bit_en(link_bit_en),
		.link_sdi(link_sdi), .link_data_read(link_data_read), .link_sdo(link_sdo));
	amc_mode_ctrl #(.DATA_W(24), .RATE_CYC({16{23'd200}}), .SETTLE_CYC(23'd50)) amc_mode_ctrl_i (
		.mclk(mclk), .rst(rst), .link_clk(link_clk), .link_frame(link_frame),
		.link_reg_select(link_reg_select), .link_write(link_write), .link_bit_en(link_bit_en),
		.link_sdi(link_sdi), .link_sdo(link_sdo), .link_data_read(link_data_read),
		.conv_result(conv_result), .data_word(data_word), .data_ready_n(data_ready_n),
		.mod_reset(mod_reset), .mod_clk_en(mod_clk_en), .conv_power_en(conv_power_en),
		.burnout_en(burnout_en), .switch_close(switch_close), .cal_active(cal_active),
		.cal_system(cal_system), .coef_store_offset(coef_store_offset),
		.coef_store_fullscale(coef_store_fullscale), .mode_word(mode_word));
	// ****************************************
	// Clock, counters and tasks
	// ****************************************
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc_n++;
		n_off += int'(coef_store_offset === 1'b1);
		n_fs += int'(coef_store_fullscale === 1'b1);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	// every word written keeps bits 11..4 zero.
	task automatic wr(input logic [15:0] w);
		int k;
		t0 = cyc_n;
		amc_host_model_i.xfer(3'h1, 1'b1, w, d);
		for (k = 0; k < 20 && mode_word !== w; k++)
			cyc(1);
		cyc(1);
	endtask : wr
	task automatic wait_rdy(input logic lvl);
		int k;
		for (k = 0; k < 1000 && data_ready_n !== lvl; k++)
			cyc(1);
		check(data_ready_n, lvl);
	endtask : wait_rdy
	initial
	begin
		#(30000 * 50);
		n_fail++;
		wrap_up();
	end
	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		rst = 1'b1;
		conv_result = 24'h5a3c71;
		amc_host_model_i.tick(4);
		cyc(2);
		rst = 1'b0;
		check(mode_word, 16'h000a);
		check(data_ready_n, 1'b1);
		amc_host_model_i.tick(4);
		amc_host_model_i.xfer(3'h1, 1'b0, 16'h0000, d);
		check(d, 16'h000a);
		wr(16'h000a);
		wait_rdy(1'b0);
		check(cyc_n - t0 >= 400 && cyc_n - t0 <= 415, 1'b1);
		check(data_word, 24'h5a3c71);
		t1 = cyc_n;
		wait_rdy(1'b1);
		wait_rdy(1'b0);
		check(cyc_n - t1 >= 199 && cyc_n - t1 <= 201, 1'b1);
		$display("test continuous done");
		wr(16'h100a);
		check(data_ready_n, 1'b1);
		check(switch_close, 1'b1);
		amc_host_model_i.xfer(3'h1, 1'b0, 16'h0000, d);
		check(d, 16'h100a);
		$display("test switch done");
		wr(16'h700a);
		cyc(3);
		check({switch_close, conv_power_en, burnout_en, mod_clk_en}, 4'h0);
		check(data_ready_n, 1'b1);
		$display("test power-down done");
		wr(16'h400a);
		cyc(300);
		check({mod_reset, mod_clk_en, conv_power_en, data_ready_n}, 4'hf);
		$display("test idle done");
		conv_result = 24'h2468ac;
		wr(16'h200a);
		wait_rdy(1'b0);
		check(cyc_n - t0 >= 450 && cyc_n - t0 <= 465, 1'b1);
		check(data_word, 24'h2468ac);
		cyc(3);
		check(conv_power_en, 1'b0);
		cyc(300);
		check(data_ready_n, 1'b0);
		amc_host_model_i.rd_pulse();
		cyc(5);
		check(data_ready_n, 1'b1);
		$display("test single done");
		conv_result = 24'h0f0f0f;
		for (int c = 4; c < 8; c++)
		begin
			t1 = n_off + n_fs;
			wr({c[2:0], 13'h000a});
			cyc(10);
			check({cal_active, cal_system}, {1'b1, c[1]});
			wait_rdy(1'b0);
			cyc(2);
			check(cyc_n - t0 >= 400 && cyc_n - t0 <= 418, 1'b1);
			check(n_off + n_fs - t1, 32'd1);
			check(n_fs, (c - 3) / 2);
			check(mode_word[15:13], 3'h2);
			check(data_word, 24'h2468ac);
		end
		$display("test calibration done");
		wrap_up();
	end
endmodule : amc_mode_ctrl_tb_top
